// >>> verilog/rai_map.svh
// Register offsets, field positions, reset values and clock rates of the receive alarm block
`ifndef RAI_MAP_SVH
`define RAI_MAP_SVH
`define RAI_IDX_LATCHED 5
`define RAI_IDX_LIVE 9
`define RAI_IDX_MASK 12
`define RAI_IDX_CTRL 16
`define RAI_ADDR_LATCHED 12'h014
`define RAI_ADDR_LIVE 12'h024
`define RAI_ADDR_MASK 12'h030
`define RAI_ADDR_CTRL 12'h040
`define RAI_BIT_SIGABS 0
`define RAI_BIT_LOCK 4
`define RAI_CTRL_IRQEN 0
`define RAI_CTRL_PUSHPULL 1
`define RAI_CTRL_CLKOUT 2
`define RAI_RST_MASK 8'h00
`define RAI_RST_CTRL 8'h00
`define RAI_CLK_HZ 125000000
`define RAI_CLKOUT_HZ 622000000
`endif

// >>> verilog/rai_pkg.sv
// Types shared by the receive alarm and interrupt block
`default_nettype none
package rai_pkg;
  typedef struct packed {
    logic analogAbsent;
    logic countAbsent;
    logic qualityAbsent;
  } rai_detect_s;
  typedef struct packed {
    logic useRef;
    logic freqLost;
    logic qualityLost;
  } rai_lock_s;
  typedef enum logic [2:0] {
    RAI_IDLE = 3'b001,
    RAI_ACCESS = 3'b010,
    RAI_DONE = 3'b100
  } rai_bus_e;
endpackage : rai_pkg
`default_nettype wire

// >>> verilog/rai_lock_detect.sv
// Receive lock-lost decision from frequency or data-quality indications
`default_nettype none
module rai_lock_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire rai_pkg::rai_lock_s lockIn,
  output logic lockLost
);
  import rai_pkg::*;
  logic lost_d;
  logic lost_q;
  // Without a reference clock only the data quality measure is meaningful
  always_comb begin
    lost_d = lockIn.useRef ? lockIn.freqLost : lockIn.qualityLost;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= lost_d;
    end
  end
  assign lockLost = lost_q;
endmodule : rai_lock_detect
`default_nettype wire

// >>> verilog/rai_irq_out.sv
// Interrupt pin driver, open-drain or push-pull, active low
`default_nettype none
module rai_irq_out (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pending,
  input wire logic pushPull,
  output logic irqOut,
  output logic irqOe
);
  import rai_pkg::*;
  logic out_d;
  logic out_q;
  logic oe_d;
  logic oe_q;
  // Open-drain only pulls low while pending; push-pull always drives the level
  always_comb begin
    out_d = ~pending;
    oe_d = pushPull | pending;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end
  assign irqOut = out_q;
  assign irqOe = oe_q;
endmodule : rai_irq_out
`default_nettype wire

// >>> verilog/rai_alarm_top.sv
// Receive alarm outputs, latched status, mask and interrupt with APB register access
//
// Notes on behaviour
// - Interrupt pin driven low on alert
// - Each source masked by its own bit
// - Status register shows every alert source
// - Global enable cleared blocks the interrupt
// - Open-drain after reset, push-pull when selected
// - Lock-lost pin high while lock lost
// - Live lock-lost at bit four, index nine
// - Latched lock-lost at bit four, index five
// - Lock-lost interrupts only when mask enabled
// - No reference: lock decided by data quality
// - Lock pin may carry 622 MHz clock
// - Signal-absent high if any detector reports
`include "rai_map.svh"
`default_nettype none
module rai_alarm_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rai_pkg::rai_detect_s detectIn,
  input wire rai_pkg::rai_lock_s lockIn,
  input wire logic txClk622,
  output logic rxLockLost,
  output logic rxSignalAbsent,
  output logic irqOut,
  output logic irqOe
);
  import rai_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Live conditions

  logic lockLost;
  logic sigAbs_d;
  logic sigAbs_q;
  logic pinLock_d;
  logic pinLock_q;
  logic [7:0] live;
  logic [7:0] latched_d;
  logic [7:0] latched_q;
  logic [7:0] mask_d;
  logic [7:0] mask_q;
  logic [7:0] ctrl_d;
  logic [7:0] ctrl_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic pending_d;
  logic pending_q;
  logic wrEn;
  logic rdEn;
  logic hit;
  logic selLatched;
  logic selLive;
  logic selMask;
  logic selCtrl;
  logic rdSetup;
  logic clrLatched;

  rai_lock_detect i_rai_lock_detect (
    .clk(clk),
    .rst_b(rst_b),
    .lockIn(lockIn),
    .lockLost(lockLost)
  );

  // Any one detector is enough to flag signal absence
  always_comb begin
    sigAbs_d = detectIn.analogAbsent | detectIn.countAbsent | detectIn.qualityAbsent;
  end

  // Place the live sources into the status layout
  always_comb begin
    live = 8'h00;
    live[`RAI_BIT_LOCK] = lockLost;
    live[`RAI_BIT_SIGABS] = sigAbs_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  function automatic logic addrIs(input logic [11:0] a, input logic [11:0] ref_a);
    addrIs = (a == ref_a);
  endfunction : addrIs

  // Zero wait states: every access completes in its first access cycle
  always_comb begin
    selLatched = addrIs(paddr, `RAI_ADDR_LATCHED);
    selLive = addrIs(paddr, `RAI_ADDR_LIVE);
    selMask = addrIs(paddr, `RAI_ADDR_MASK);
    selCtrl = addrIs(paddr, `RAI_ADDR_CTRL);
    wrEn = psel & penable & pwrite;
    rdEn = psel & penable & ~pwrite;
    rdSetup = psel & ~penable & ~pwrite;
    hit = selLatched | selLive | selMask | selCtrl;
    clrLatched = rdEn & selLatched;
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Signal-absent flag is registered so the pin never shows detector glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sigAbs_q <= 1'b0;
    end else begin
      sigAbs_q <= sigAbs_d;
    end
  end

  // Sticky latch: a new event in the clearing read cycle survives the clear
  always_comb begin
    latched_d = latched_q;
    if (clrLatched) begin
      latched_d = 8'h00;
    end
    latched_d = latched_d | live;
  end

  // Status bits are set only by live sources and cleared only by a status read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latched_q <= 8'h00;
    end else begin
      latched_q <= latched_d;
    end
  end

  // Mask keeps only the low byte and control only bits 2:0; upper write bits are dropped
  always_comb begin
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    if (wrEn && selMask) begin
      mask_d = pwdata[7:0];
    end
    if (wrEn && selCtrl) begin
      ctrl_d = {5'h00, pwdata[2:0]};
    end
  end

  // Configuration words; status and unmapped writes never land here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `RAI_RST_MASK;
      ctrl_q <= `RAI_RST_CTRL;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Read mux; the latched word is captured before it is cleared
  always_comb begin
    rdata_d = rdata_q;
    if (rdSetup) begin
      if (selLatched) begin
        rdata_d = {24'h000000, latched_q | live};
      end else if (selLive) begin
        rdata_d = {24'h000000, live};
      end else if (selMask) begin
        rdata_d = {24'h000000, mask_q};
      end else if (selCtrl) begin
        rdata_d = {24'h000000, ctrl_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // Read data is held between reads so a slow master still sees it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pending alert gated by per-source mask and global enable
  always_comb begin
    pending_d = (|(latched_q & mask_q)) & ctrl_q[`RAI_CTRL_IRQEN];
  end

  // Registered pending keeps the pin free of decode glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
    end
  end

  // Lock pin carries either the lock flag or the transmit-side clock
  always_comb begin
    pinLock_d = lockLost;
  end

  // Lock flag as it leaves on the pin when clock-out is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinLock_q <= 1'b0;
    end else begin
      pinLock_q <= pinLock_d;
    end
  end

  assign prdata = rdata_q;
  assign rxSignalAbsent = sigAbs_q;
  // The 622 MHz clock is far above the core rate, so it is muxed, not registered
  assign rxLockLost = ctrl_q[`RAI_CTRL_CLKOUT] ? txClk622 : pinLock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  rai_irq_out i_rai_irq_out (
    .clk(clk),
    .rst_b(rst_b),
    .pending(pending_q),
    .pushPull(ctrl_q[`RAI_CTRL_PUSHPULL]),
    .irqOut(irqOut),
    .irqOe(irqOe)
  );
endmodule : rai_alarm_top
`default_nettype wire

// >>> tb/rai_host_model.sv
// Host side of the alert line
`default_nettype none
module rai_host_model (
  input wire logic irqOut,
  input wire logic irqOe,
  output logic irqPin
);
  timeunit 1ns / 1ps;
  // A released line reads high through the pull-up
  assign irqPin = irqOe ? irqOut : 1'b1;
endmodule : rai_host_model
`default_nettype wire

// >>> tb/rai_alarm_checker.sv
// Port assertions for the receive alarm block
`default_nettype none
module rai_alarm_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire rai_pkg::rai_detect_s detectIn,
  input wire rai_pkg::rai_lock_s lockIn,
  input wire logic txClk622,
  input wire logic rxLockLost,
  input wire logic rxSignalAbsent,
  input wire logic irqOut,
  input wire logic irqOe
);
  timeunit 1ns / 1ps;
  logic acc, dec, ok;
  // Access phase, lock decision, address decode
  assign acc = psel && penable;
  assign dec = lockIn.useRef ? lockIn.freqLost : lockIn.qualityLost;
  assign ok = paddr inside {12'h014, 12'h024, 12'h030, 12'h040};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_sig_follow: assert property (rxSignalAbsent == |$past(detectIn))
    else $error("signal flag");
  a_lock_clear: assert property (!$past(dec, 2) && !txClk622 |-> !rxLockLost)
    else $error("lock stuck");
  a_lock_set: assert property ($past(dec, 2) && txClk622 |-> rxLockLost)
    else $error("lock missing");
  a_drive_low: assert property (!irqOut |-> irqOe)
    else $error("low undriven");
  a_od_reset: assert property ($rose(rst_b) |-> irqOut && !irqOe)
    else $error("driven at reset");
  a_bad_addr: assert property (acc |-> pslverr == !ok && (ok || pwrite || prdata == 0))
    else $error("error reply");
  a_live_read: assert property (acc && !pwrite && paddr == 12'h024 && $stable(rxSignalAbsent)
    |-> prdata[0] == rxSignalAbsent) else $error("live bit");
  a_irq_hold: assert property (!irqOut && !$past(acc) && !$past(acc, 2) |=> !irqOut)
    else $error("alert dropped");
  c_alert: cover property (!irqOut);
  c_push_idle: cover property (irqOe && irqOut);
  c_refused: cover property (acc && pslverr);
endmodule : rai_alarm_checker
`default_nettype wire

// >>> tb/test_rx_alarm_interrupt_outputs.sv
// Bench for the receive alarm block
`default_nettype none
module test_rx_alarm_interrupt_outputs;
  timeunit 1ns / 1ps;
  import rai_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, txClk622;
  logic rxLockLost, rxSignalAbsent, irqOut, irqOe, irqPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  rai_detect_s detectIn;
  rai_lock_s lockIn;
  logic [12:0] expQ[$];
  int failCount, checkCount;
  rai_alarm_top i_rai_alarm_top (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .detectIn, .lockIn, .txClk622, .rxLockLost, .rxSignalAbsent, .irqOut, .irqOe);
  rai_host_model i_rai_host_model (.irqOut, .irqOe, .irqPin);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Random level stands in for the transmit clock
  always @(posedge clk) txClk622 <= 1'($urandom);
  task automatic completeRun();
    if (failCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : completeRun
  // Request held until ready is seen; idle edge first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready && ++n < 20);
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      failCount++;
      $display("MISMATCH %0t %h %h", $time, pready, 1'b1);
      completeRun();
    end
  endtask : apb
  // Expected word is {error, lock pin, signal pin, enable, irq pin, data byte}
  task automatic rd(input logic [11:0] a, input logic [12:0] e);
    repeat (4) @(posedge clk);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Each read is judged with the pin state beside it
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      checkCount++;
      if ({pslverr, rxLockLost, rxSignalAbsent, irqOe, irqPin, prdata[7:0]} !== expQ[0] || prdata[31:8] !== 24'h0) begin
        failCount++;
        $display("MISMATCH %0t %h %h", $time, {pslverr, rxLockLost, rxSignalAbsent, irqOe, irqPin, prdata}, expQ[0]);
      end
      void'(expQ.pop_front());
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, detectIn, lockIn} = '0;
    {failCount, checkCount} = '0;
    void'($urandom(32'h89f6));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h040, 13'h0100);
    rd(12'h100, 13'h1100);
    detectIn <= 3'($urandom_range(7, 1));
    lockIn <= 3'b001;
    rd(12'h024, 13'h0d11);
    rd(12'h014, 13'h0d11);
    apb(1'b1, 12'h030, 32'h10);
    apb(1'b1, 12'h040, 32'h1);
    rd(12'h040, 13'h0e01);
    {detectIn, lockIn} <= '0;
    rd(12'h014, 13'h0211);
    rd(12'h014, 13'h0100);
    apb(1'b1, 12'h040, 32'h0);
    lockIn <= 3'b001;
    rd(12'h024, 13'h0910);
    apb(1'b1, 12'h040, 32'h3);
    rd(12'h040, 13'h0a03);
    lockIn <= 3'b101;
    rd(12'h014, 13'h0210);
    rd(12'h040, 13'h0303);
    lockIn <= 3'b110;
    apb(1'b1, 12'h040, 32'h4);
    // Clock-out mode: the lock pin must follow the transmit clock level
    repeat (8) begin
      @(posedge clk);
      checkCount++;
      if (rxLockLost !== txClk622) begin
        failCount++;
        $display("MISMATCH %0t %h %h", $time, rxLockLost, txClk622);
      end
    end
    completeRun();
  end
endmodule : test_rx_alarm_interrupt_outputs
bind rai_alarm_top rai_alarm_checker i_rai_alarm_checker (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .detectIn, .lockIn, .txClk622, .rxLockLost, .rxSignalAbsent, .irqOut, .irqOe);
`default_nettype wire
